// ==== common/tim_pkg.sv ====
package tim_pkg;

    // ****************************************
    // register offsets (byte index; byte address is four times this)
    // ****************************************
    localparam int NUM_CH = 8;
    localparam logic [7:0] IDX_MODE_SEL = 8'h00;
    localparam logic [7:0] IDX_FORCE = 8'h01;
    localparam logic [7:0] IDX_MASK = 8'h02;
    localparam logic [7:0] IDX_DATA = 8'h03;
    localparam logic [7:0] IDX_CNT_HI = 8'h04;
    localparam logic [7:0] IDX_CNT_LO = 8'h05;
    localparam logic [7:0] IDX_SCR1 = 8'h06;
    localparam logic [7:0] IDX_TOGGLE = 8'h07;
    localparam logic [7:0] IDX_ACT_HI = 8'h08;
    localparam logic [7:0] IDX_ACT_LO = 8'h09;
    localparam logic [7:0] IDX_EDGE_HI = 8'h0A;
    localparam logic [7:0] IDX_EDGE_LO = 8'h0B;
    localparam logic [7:0] IDX_IRQ_EN = 8'h0C;
    localparam logic [7:0] IDX_SCR2 = 8'h0D;
    localparam logic [7:0] IDX_FLAGS = 8'h0E;
    localparam logic [7:0] IDX_OVF = 8'h0F;
    localparam logic [7:0] IDX_VALUE = 8'h10;
    localparam logic [7:0] IDX_ACC_CTL = 8'h20;
    localparam logic [7:0] IDX_ACC_FLG = 8'h21;
    localparam logic [7:0] IDX_ACC_HI = 8'h22;
    localparam logic [7:0] IDX_ACC_LO = 8'h23;
    localparam logic [7:0] IDX_TEST_MODE = 8'h30;

    // ****************************************
    // field positions, masks and reset values
    // ****************************************
    localparam int SCR1_EN_BIT = 7;
    localparam int SCR1_FFCA_BIT = 4;
    localparam logic [7:0] SCR1_MASK = 8'hF0;
    localparam logic [7:0] SCR2_MASK = 8'h8F;
    localparam logic [7:0] OVF_MASK = 8'h80;
    localparam logic [7:0] ACC_CTL_MASK = 8'h7F;
    localparam logic [7:0] ACC_FLG_MASK = 8'h03;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    // output compare pin actions (two bits per channel)
    typedef enum logic [1:0] {ACT_NONE, ACT_TOGGLE, ACT_CLEAR, ACT_SET} pin_act_e;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_s;

    typedef struct packed {
        logic [7:0] pin_out;
        logic [7:0] pin_oe;
    } pin_drv_s;

endpackage : tim_pkg

// ==== core/oc_channel.sv ====
`timescale 1ns/1ps
module oc_channel
    import tim_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // channel control
    input wire logic oc_mode,
    input wire logic [15:0] cmp_value,
    input wire logic [15:0] counter,
    input wire logic cnt_run,
    input wire logic force_pulse,
    input wire logic [1:0] action,
    // channel 7 override
    input wire logic master_hit,
    input wire logic master_mask,
    input wire logic master_data,
    // results
    output logic match,
    output logic pin_level
);

    typedef struct packed {
        logic pin;
    } chan_state_s;

    chan_state_s st_ff;
    chan_state_s nxt_st;

    // a genuine match happens only on a counting cycle in compare mode
    assign match = oc_mode && cnt_run && (counter == cmp_value);
    assign pin_level = st_ff.pin;

    // pin action: channel 7 override first, then forced or matched action
    always_comb
    begin
        nxt_st = st_ff;
        if (master_hit && master_mask)
        begin
            nxt_st.pin = master_data; // RULE6 RULE9
        end
        else if (oc_mode && (force_pulse || match)) // RULE4 RULE7
        begin
            unique case (pin_act_e'(action))
                ACT_NONE: nxt_st.pin = st_ff.pin;
                ACT_TOGGLE: nxt_st.pin = ~st_ff.pin;
                ACT_CLEAR: nxt_st.pin = 1'b0;
                ACT_SET: nxt_st.pin = 1'b1;
            endcase
        end
    end

    // pin level register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

endmodule : oc_channel

// ==== core/timer_capture_compare_regs.sv ====
`timescale 1ns/1ps
// Functional notes
// RULE1: each of eight channels picks capture or compare by its own mode bit
// RULE2: mode bit zero means input capture, one means output compare
// RULE3: force register takes writes anytime and always reads as zero
// RULE4: writing one to a force bit performs the channel's compare pin action now
// RULE5: a forced action never sets the channel flag
// RULE6: channel 7 compare overrides channels 6 to 0 on masked pins
// RULE7: forced and genuine compare together: forced wins, flag stays clear
// RULE8: mask bit set on a compare channel 0 to 6 makes its pin an output
// RULE9: on channel 7 compare, masked pins take the matching master data bit
// RULE10: mode select, master mask and master data are read/write anytime
// RULE11: value register writes are ignored while the channel is in capture mode
// RULE12: the main counter is a sixteen bit up counter
// RULE13: reserved addresses ignore writes and read zero
module timer_capture_compare_regs
    import tim_pkg::*;
#(
    parameter int NCH = NUM_CH
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // apb slave
    input wire apb_req_s apb_req,
    output apb_rsp_s apb_rsp,
    // capture/compare pins
    input wire logic [7:0] pin_in,
    output pin_drv_s pin_drv,
    // channel flags for the system
    output logic [7:0] chan_flags
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [7:0] mode_sel;
        logic [7:0] mask;
        logic [7:0] data;
        logic [15:0] counter;
        logic [7:0] scr1;
        logic [7:0] toggle;
        logic [15:0] act;
        logic [15:0] edges;
        logic [7:0] irq_en;
        logic [7:0] scr2;
        logic [7:0] flags;
        logic [7:0] ovf;
        logic [7:0] acc_ctl;
        logic [7:0] acc_flg;
        logic [15:0] acc_cnt;
        logic test_mode;
        logic [7:0] force_req;
        logic [7:0] pin_prev;
        logic [NCH*16-1:0] value;
        logic [31:0] prdata;
        logic pready;
        logic [7:0] pin_out;
        logic [7:0] pin_oe;
    } regs_s;

    regs_s r_ff;
    regs_s nxt_r;

    logic [7:0] match;
    logic [7:0] pin_level;
    logic [7:0] byte_idx;
    logic wr_take;
    logic rd_take;
    logic cnt_run;
    logic master_hit;
    logic [7:0] flag_set;

    // ****************************************
    // bus decode
    // ****************************************
    assign byte_idx = apb_req.paddr[9:2];
    assign wr_take = apb_req.psel && apb_req.penable && apb_req.pwrite && r_ff.pready;
    assign rd_take = apb_req.psel && apb_req.penable && !apb_req.pwrite && !r_ff.pready;
    assign cnt_run = r_ff.scr1[SCR1_EN_BIT];
    // channel 7 hit by a genuine match or a forced compare
    assign master_hit = r_ff.mode_sel[7] && (match[7] || r_ff.force_req[7]); // RULE6

    // ****************************************
    // compare channels
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++)
        begin : g_ch
            oc_channel u_ch (
                .clk(clk),
                .rstn(rstn),
                .oc_mode(r_ff.mode_sel[gi]), // RULE1 RULE2
                .cmp_value(r_ff.value[gi*16 +: 16]),
                .counter(r_ff.counter),
                .cnt_run(cnt_run),
                .force_pulse(r_ff.force_req[gi]),
                .action(r_ff.act[gi*2 +: 2]),
                .master_hit(master_hit && (gi != 7)),
                .master_mask(r_ff.mask[gi]),
                .master_data(r_ff.data[gi]),
                .match(match[gi]),
                .pin_level(pin_level[gi])
            );
        end
    endgenerate

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        nxt_r = r_ff;
        nxt_r.pready = 1'b0;
        nxt_r.force_req = 8'h00; // transient, lasts one cycle
        nxt_r.pin_prev = pin_in;
        flag_set = 8'h00; // events of this cycle; a clear written now loses to them

        // up counter
        if (cnt_run)
            nxt_r.counter = r_ff.counter + 16'h0001; // RULE12
        if (cnt_run && (r_ff.counter == 16'hFFFF))
            nxt_r.ovf[7] = 1'b1;

        // capture on selected edge; compare flag only from a genuine match
        for (int i = 0; i < NCH; i++)
        begin
            if (!r_ff.mode_sel[i])
            begin
                if ((r_ff.edges[i*2] && !r_ff.pin_prev[i] && pin_in[i]) ||
                    (r_ff.edges[i*2+1] && r_ff.pin_prev[i] && !pin_in[i]))
                begin
                    nxt_r.value[i*16 +: 16] = r_ff.counter;
                    nxt_r.flags[i] = 1'b1;
                    flag_set[i] = 1'b1;
                end
            end
            else if (match[i] && !r_ff.force_req[i])
            begin
                nxt_r.flags[i] = 1'b1; // RULE5 RULE7
                flag_set[i] = 1'b1;
            end
        end

        // pins: compare channels with a pin action drive; mask makes compare channels 0..6 outputs
        for (int i = 0; i < NCH; i++)
        begin
            nxt_r.pin_oe[i] = r_ff.mode_sel[i] &&
                ((r_ff.act[i*2 +: 2] != 2'b00) || (i != 7 && r_ff.mask[i])); // RULE8
            nxt_r.pin_out[i] = pin_level[i];
        end

        // one-wait-state read: data set up in the first access cycle
        if (apb_req.psel && apb_req.penable && !r_ff.pready)
        begin
            nxt_r.pready = 1'b1;
            nxt_r.prdata = RD_ZERO;
            if (!apb_req.pwrite)
            begin
                unique case (byte_idx)
                    IDX_MODE_SEL: nxt_r.prdata[7:0] = r_ff.mode_sel; // RULE10
                    IDX_FORCE: nxt_r.prdata[7:0] = RST_BYTE; // RULE3
                    IDX_MASK: nxt_r.prdata[7:0] = r_ff.mask;
                    IDX_DATA: nxt_r.prdata[7:0] = r_ff.data;
                    IDX_CNT_HI: nxt_r.prdata[7:0] = r_ff.counter[15:8];
                    IDX_CNT_LO: nxt_r.prdata[7:0] = r_ff.counter[7:0];
                    IDX_SCR1: nxt_r.prdata[7:0] = r_ff.scr1;
                    IDX_TOGGLE: nxt_r.prdata[7:0] = r_ff.toggle;
                    IDX_ACT_HI: nxt_r.prdata[7:0] = r_ff.act[15:8];
                    IDX_ACT_LO: nxt_r.prdata[7:0] = r_ff.act[7:0];
                    IDX_EDGE_HI: nxt_r.prdata[7:0] = r_ff.edges[15:8];
                    IDX_EDGE_LO: nxt_r.prdata[7:0] = r_ff.edges[7:0];
                    IDX_IRQ_EN: nxt_r.prdata[7:0] = r_ff.irq_en;
                    IDX_SCR2: nxt_r.prdata[7:0] = r_ff.scr2;
                    IDX_FLAGS: nxt_r.prdata[7:0] = r_ff.flags;
                    IDX_OVF: nxt_r.prdata[7:0] = r_ff.ovf;
                    IDX_ACC_CTL: nxt_r.prdata[7:0] = r_ff.acc_ctl;
                    IDX_ACC_FLG: nxt_r.prdata[7:0] = r_ff.acc_flg;
                    IDX_ACC_HI: nxt_r.prdata[7:0] = r_ff.acc_cnt[15:8];
                    IDX_ACC_LO: nxt_r.prdata[7:0] = r_ff.acc_cnt[7:0];
                    IDX_TEST_MODE: nxt_r.prdata[0] = r_ff.test_mode;
                    default:
                    begin
                        if (byte_idx >= IDX_VALUE && byte_idx < IDX_ACC_CTL)
                            nxt_r.prdata[7:0] = byte_idx[0] ?
                                r_ff.value[byte_idx[3:1]*16 +: 8] :
                                r_ff.value[byte_idx[3:1]*16 + 8 +: 8];
                        else
                            nxt_r.prdata = RD_ZERO; // RULE13
                    end
                endcase
            end
        end

        // fast clear: reading a capture value clears its flag
        if (rd_take && r_ff.scr1[SCR1_FFCA_BIT] && byte_idx >= IDX_VALUE && byte_idx < IDX_ACC_CTL
            && !r_ff.mode_sel[byte_idx[3:1]] && !flag_set[byte_idx[3:1]])
            nxt_r.flags[byte_idx[3:1]] = 1'b0;

        // register writes take effect at the completing edge
        if (wr_take)
        begin
            unique case (byte_idx)
                IDX_MODE_SEL: nxt_r.mode_sel = apb_req.pwdata[7:0]; // RULE10
                IDX_FORCE: nxt_r.force_req = apb_req.pwdata[7:0]; // RULE3 RULE4
                IDX_MASK: nxt_r.mask = apb_req.pwdata[7:0];
                IDX_DATA: nxt_r.data = apb_req.pwdata[7:0];
                IDX_CNT_HI:
                    if (r_ff.test_mode)
                        nxt_r.counter[15:8] = apb_req.pwdata[7:0];
                IDX_CNT_LO:
                    if (r_ff.test_mode)
                        nxt_r.counter[7:0] = apb_req.pwdata[7:0];
                IDX_SCR1: nxt_r.scr1 = apb_req.pwdata[7:0] & SCR1_MASK;
                IDX_TOGGLE: nxt_r.toggle = apb_req.pwdata[7:0];
                IDX_ACT_HI: nxt_r.act[15:8] = apb_req.pwdata[7:0];
                IDX_ACT_LO: nxt_r.act[7:0] = apb_req.pwdata[7:0];
                IDX_EDGE_HI: nxt_r.edges[15:8] = apb_req.pwdata[7:0];
                IDX_EDGE_LO: nxt_r.edges[7:0] = apb_req.pwdata[7:0];
                IDX_IRQ_EN: nxt_r.irq_en = apb_req.pwdata[7:0];
                IDX_SCR2: nxt_r.scr2 = apb_req.pwdata[7:0] & SCR2_MASK;
                // write one to clear; a simultaneous set wins
                IDX_FLAGS: nxt_r.flags = nxt_r.flags & ~(apb_req.pwdata[7:0] & ~flag_set);
                IDX_OVF: nxt_r.ovf = nxt_r.ovf & ~(apb_req.pwdata[7:0] & r_ff.ovf & OVF_MASK);
                IDX_ACC_CTL: nxt_r.acc_ctl = apb_req.pwdata[7:0] & ACC_CTL_MASK;
                IDX_ACC_FLG: nxt_r.acc_flg = r_ff.acc_flg & ~(apb_req.pwdata[7:0] & ACC_FLG_MASK);
                IDX_ACC_HI: nxt_r.acc_cnt[15:8] = apb_req.pwdata[7:0];
                IDX_ACC_LO: nxt_r.acc_cnt[7:0] = apb_req.pwdata[7:0];
                IDX_TEST_MODE: nxt_r.test_mode = apb_req.pwdata[0];
                default:
                begin
                    // value bytes only in compare mode; reserved space ignored
                    if (byte_idx >= IDX_VALUE && byte_idx < IDX_ACC_CTL && r_ff.mode_sel[byte_idx[3:1]]) // RULE11
                    begin
                        if (byte_idx[0])
                            nxt_r.value[byte_idx[3:1]*16 +: 8] = apb_req.pwdata[7:0];
                        else
                            nxt_r.value[byte_idx[3:1]*16 + 8 +: 8] = apb_req.pwdata[7:0];
                        if (r_ff.scr1[SCR1_FFCA_BIT] && !match[byte_idx[3:1]])
                            nxt_r.flags[byte_idx[3:1]] = 1'b0;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            r_ff <= '0;
        else
            r_ff <= nxt_r;
    end

    assign apb_rsp.pready = r_ff.pready;
    assign apb_rsp.pslverr = 1'b0;
    assign apb_rsp.prdata = r_ff.prdata;
    assign pin_drv.pin_out = r_ff.pin_out;
    assign pin_drv.pin_oe = r_ff.pin_oe;
    assign chan_flags = r_ff.flags;

    // ****************************************
    // checks
    // ****************************************
    sequence s_force_write(int ch);
        wr_take && byte_idx == IDX_FORCE && apb_req.pwdata[ch];
    endsequence

    a_force_reads_zero: assert property (@(posedge clk) disable iff (!rstn) // RULE3
        rd_take && byte_idx == IDX_FORCE |=> apb_rsp.prdata == RD_ZERO)
        else $error("force register read not zero");
    a_force_no_flag: assert property (@(posedge clk) disable iff (!rstn) // RULE5
        s_force_write(0) ##1 (r_ff.mode_sel[0] && !match[0] && !r_ff.flags[0]) |=> !r_ff.flags[0])
        else $error("forced compare set a flag");
    a_force_sets_pin: assert property (@(posedge clk) disable iff (!rstn) // RULE4
        s_force_write(0) ##1 (r_ff.mode_sel[0] && r_ff.act[1:0] == 2'b11 && !master_hit) |=> ##1 pin_drv.pin_out[0])
        else $error("forced set action missing");
    a_master_data_wins: assert property (@(posedge clk) disable iff (!rstn) // RULE6
        master_hit && r_ff.mask[2] |=> ##1 pin_drv.pin_out[2] == $past(r_ff.data[2], 2))
        else $error("channel 7 override lost");
    a_mask_makes_output: assert property (@(posedge clk) disable iff (!rstn) // RULE8
        r_ff.mode_sel[3] && r_ff.mask[3] |=> pin_drv.pin_oe[3])
        else $error("masked compare pin not output");
    a_capture_write_ignored: assert property (@(posedge clk) disable iff (!rstn) // RULE11
        wr_take && byte_idx == IDX_VALUE && !r_ff.mode_sel[0] && r_ff.edges[1:0] == 2'b00 |=> $stable(r_ff.value[15:0]))
        else $error("capture value overwritten");
    a_counter_counts: assert property (@(posedge clk) disable iff (!rstn) // RULE12
        cnt_run && !wr_take |=> r_ff.counter == $past(r_ff.counter) + 16'h0001)
        else $error("counter did not count up");
    a_reserved_zero: assert property (@(posedge clk) disable iff (!rstn) // RULE13
        rd_take && byte_idx > IDX_ACC_LO && byte_idx < IDX_TEST_MODE |=> apb_rsp.prdata == RD_ZERO)
        else $error("reserved read not zero");
    a_mode_readback: assert property (@(posedge clk) disable iff (!rstn) // RULE10
        wr_take && byte_idx == IDX_MODE_SEL |=> r_ff.mode_sel == $past(apb_req.pwdata[7:0]))
        else $error("mode select write lost");
    a_mask_readback: assert property (@(posedge clk) disable iff (!rstn) // RULE10
        wr_take && byte_idx == IDX_MASK |=> r_ff.mask == $past(apb_req.pwdata[7:0]))
        else $error("master mask write lost");

    // ****************************************
    // event and pin checks
    // ****************************************
    // forced and genuine compare on channel 3 in one cycle
    sequence s_force_and_match;
        r_ff.force_req[3] && match[3] && !r_ff.flags[3];
    endsequence

    // channel 7 event reaching masked pin 0
    sequence s_master_pin0;
        master_hit && r_ff.mask[0];
    endsequence

    a_force_beats_match: assert property (@(posedge clk) disable iff (!rstn) // RULE7
        s_force_and_match |=> !r_ff.flags[3])
        else $error("forced compare lost to match");
    a_master_data_pin0: assert property (@(posedge clk) disable iff (!rstn) // RULE9
        s_master_pin0 |=> ##1 pin_drv.pin_out[0] == $past(r_ff.data[0], 2))
        else $error("masked pin missed master data");
    a_match_sets_flag: assert property (@(posedge clk) disable iff (!rstn) // RULE5
        match[1] && !r_ff.force_req[1] |=> r_ff.flags[1])
        else $error("genuine match left flag clear");
    a_force_transient: assert property (@(posedge clk) disable iff (!rstn) // RULE3
        (|r_ff.force_req) |=> r_ff.force_req == 8'h00)
        else $error("force request lingered");

    // counter and pin direction
    a_capture_pin_input: assert property (@(posedge clk) disable iff (!rstn) // RULE2
        !r_ff.mode_sel[4] |=> !pin_drv.pin_oe[4])
        else $error("capture pin driven");
    a_mask_skips_ch7: assert property (@(posedge clk) disable iff (!rstn) // RULE8
        r_ff.mode_sel[7] && r_ff.act[15:14] == 2'b00 |=> !pin_drv.pin_oe[7])
        else $error("channel 7 pin driven by mask");
    a_counter_stopped: assert property (@(posedge clk) disable iff (!rstn) // RULE12
        !cnt_run && !wr_take |=> $stable(r_ff.counter))
        else $error("counter moved while stopped");

endmodule : timer_capture_compare_regs

// ==== verification/pin_model.sv ====
`timescale 1ns/1ps
module pin_model
    import tim_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // pins as driven by the timer
    input wire pin_drv_s pin_drv,
    // levels seen back on the pins
    output logic [7:0] pin_in
);
    // level of a released pin; flips every cycle so no stale value survives
    logic [7:0] float_ff;

    // outside world: undriven pins keep wandering
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            float_ff <= 8'h00;
        end
        else
        begin
            float_ff <= ~pin_in;
        end
    end

    // wire level: driven pins read back the timer's level
    assign pin_in = (pin_drv.pin_oe & pin_drv.pin_out) | (~pin_drv.pin_oe & float_ff);
endmodule : pin_model

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
module testbench
    import tim_pkg::*;
    ;
    // ****************************************
    // signals and instances
    // ****************************************
    logic clk;
    logic rstn;
    apb_req_s apb_req;
    apb_rsp_s apb_rsp;
    logic [7:0] pin_in;
    pin_drv_s pin_drv;
    logic [7:0] chan_flags;
    int n_errors;
    int cmp_count;
    int seed;

    timer_capture_compare_regs #(.NCH(NUM_CH)) i_timer_capture_compare_regs (
        .clk(clk), .rstn(rstn), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .pin_in(pin_in), .pin_drv(pin_drv), .chan_flags(chan_flags));

    pin_model i_pin_model (.clk(clk), .rstn(rstn), .pin_drv(pin_drv), .pin_in(pin_in));

    // free-running module clock
    always #12.5 clk = ~clk;

    // ****************************************
    // helpers
    // ****************************************
    task finish_test();
        $display("checks: %0d compares, %0d mismatches", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test

    task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // one apb transfer: setup, access, hold until pready sampled high
    task apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
        int n;
        @(posedge clk);
        apb_req.psel <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite <= wr;
        apb_req.paddr <= {2'b00, idx, 2'b00};
        apb_req.pwdata <= {24'h000000, wd};
        @(posedge clk);
        apb_req.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (apb_rsp.pready !== 1'b1 && n < 16);
        rd = apb_rsp.prdata[7:0];
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        if (n >= 16)
        begin
            n_errors++;
            $display("[ERR] %0t bus transfer never answered", $time);
            finish_test();
        end
    endtask : apb

    task wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [7:0] dummy;
        apb(1'b1, idx, wd, dummy);
    endtask : wr

    task rd_chk(input logic [7:0] idx, input logic [7:0] exp, input string what);
        logic [7:0] got;
        apb(1'b0, idx, 8'h00, got);
        chk(got, exp, what);
    endtask : rd_chk

    // expected pin level after one compare action
    function automatic logic exp_pin(input pin_act_e act, input logic cur);
        case (act)
            ACT_SET: return 1'b1;
            ACT_CLEAR: return 1'b0;
            ACT_TOGGLE: return ~cur;
            default: return cur;
        endcase
    endfunction : exp_pin

    // force channel 0 (and 7 if asked) then look at pin 0 once it has settled
    task force_chk(input logic [7:0] fbits, input logic exp, input string what);
        wr(IDX_FORCE, fbits);
        repeat (3) @(posedge clk);
        chk({7'h00, pin_drv.pin_out[0]}, {7'h00, exp}, what);
        chk({7'h00, chan_flags[0]}, 8'h00, "forced action left flag clear");
    endtask : force_chk

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        logic [7:0] r;
        logic [7:0] a;
        logic [7:0] b;
        logic cur;
        int n;
        pin_act_e acts[5];
        clk = 1'b0;
        rstn = 1'b0;
        apb_req = '0;
        n_errors = 0;
        cmp_count = 0;
        seed = 32'h30bd;
        acts = '{ACT_SET, ACT_CLEAR, ACT_TOGGLE, ACT_TOGGLE, ACT_NONE};
        repeat (4) @(posedge clk);
        rstn <= 1'b1;

        // reset values of the control registers
        rd_chk(IDX_MODE_SEL, RST_BYTE, "mode select reset");
        rd_chk(IDX_MASK, RST_BYTE, "master mask reset");
        rd_chk(IDX_DATA, RST_BYTE, "master data reset");
        $display("reset test done");

        // random read/write, force reads zero, reserved space ignored
        for (int i = 0; i < 8; i++)
        begin
            r = 8'($random(seed));
            wr(IDX_MODE_SEL, r);
            rd_chk(IDX_MODE_SEL, r, "mode select readback");
            r = 8'($random(seed));
            wr(IDX_MASK, r);
            rd_chk(IDX_MASK, r, "master mask readback");
            r = 8'($random(seed));
            wr(IDX_DATA, r);
            rd_chk(IDX_DATA, r, "master data readback");
            wr(IDX_FORCE, 8'($random(seed)));
            rd_chk(IDX_FORCE, 8'h00, "force reads zero");
            a = (i % 3 == 0) ? 8'h24 : ((i % 3 == 1) ? 8'h2C : 8'h2E);
            wr(a, 8'($random(seed)));
            rd_chk(a, 8'h00, "reserved reads zero");
        end
        $display("random register test done");

        // value writes gated by capture mode
        wr(IDX_MODE_SEL, 8'h00);
        wr(IDX_VALUE, 8'h5A);
        rd_chk(IDX_VALUE, 8'h00, "value write ignored in capture");
        wr(IDX_MODE_SEL, 8'h01);
        wr(IDX_VALUE, 8'h5A);
        wr(IDX_VALUE + 8'h01, 8'hA5);
        rd_chk(IDX_VALUE, 8'h5A, "value high in compare");
        rd_chk(IDX_VALUE + 8'h01, 8'hA5, "value low in compare");
        $display("capture gating test done");

        // forced actions on channel 0, every action code
        wr(IDX_MODE_SEL, 8'hFF);
        wr(IDX_MASK, 8'h00);
        cur = 1'bx;
        foreach (acts[k])
        begin
            wr(IDX_ACT_LO, {6'h00, acts[k]});
            cur = exp_pin(acts[k], cur);
            force_chk(8'h01, cur, "forced pin action");
        end
        $display("force test done");

        // channel 7 override on masked pin 0
        wr(IDX_ACT_LO, {6'h00, ACT_SET});
        wr(IDX_MASK, 8'h01);
        wr(IDX_DATA, 8'h00);
        force_chk(8'h81, 1'b0, "master data beats set");
        wr(IDX_DATA, 8'h01);
        wr(IDX_ACT_LO, {6'h00, ACT_CLEAR});
        force_chk(8'h81, 1'b1, "master data beats clear");
        wr(IDX_ACT_LO, 8'h00);
        repeat (3) @(posedge clk);
        chk({7'h00, pin_drv.pin_oe[0]}, 8'h01, "masked compare pin drives");
        $display("master override test done");

        // counter runs upward; genuine match sets flag, force does not
        wr(IDX_MASK, 8'h00);
        wr(IDX_MODE_SEL, 8'h06);
        wr(IDX_VALUE + 8'h02, 8'h00);
        wr(IDX_VALUE + 8'h03, 8'h40);
        wr(IDX_VALUE + 8'h04, 8'hFF);
        wr(IDX_VALUE + 8'h05, 8'hFF);
        wr(IDX_CNT_LO, 8'h77);
        rd_chk(IDX_CNT_LO, 8'h00, "counter write ignored while stopped");
        wr(IDX_SCR1, 8'h80);
        apb(1'b0, IDX_CNT_LO, 8'h00, a);
        apb(1'b0, IDX_CNT_LO, 8'h00, b);
        chk({7'h00, (8'(b - a) inside {[8'd1:8'd16]})}, 8'h01, "counter counts up");
        wr(IDX_FORCE, 8'h04);
        n = 0;
        while (chan_flags[1] !== 1'b1 && n < 300)
        begin
            @(posedge clk);
            n++;
        end
        chk({7'h00, chan_flags[1]}, 8'h01, "genuine match sets flag");
        chk({7'h00, chan_flags[2]}, 8'h00, "force leaves flag clear");
        wr(IDX_FLAGS, 8'h02);
        repeat (2) @(posedge clk);
        chk({7'h00, chan_flags[1]}, 8'h00, "flag cleared by write one");
        // stop, aim channel 3 four counts ahead, restart and force it on that count
        wr(IDX_SCR1, 8'h00);
        apb(1'b0, IDX_CNT_HI, 8'h00, a);
        apb(1'b0, IDX_CNT_LO, 8'h00, b);
        wr(IDX_MODE_SEL, 8'h0E);
        wr(IDX_VALUE + 8'h06, a);
        wr(IDX_VALUE + 8'h07, 8'(b + 8'd4));
        wr(IDX_ACT_LO, 8'hC0);
        wr(IDX_SCR1, 8'h80);
        wr(IDX_FORCE, 8'h08);
        repeat (2) @(posedge clk);
        chk({7'h00, chan_flags[3]}, 8'h00, "force beats simultaneous match");
        $display("counter and match test done");
        finish_test();
    end
endmodule : testbench
